// ===== logic/bkclk_top.sv
// Summary of operation
// - Backup register resets to 0x18, backup reset only.
// - Crystal, bypass, source, gate survive system reset.
// - Protected fields writable only with backup write enable.
// - Backup reset bit holds backup domain reset.
// - Rtc gate bit passes or blocks rtc clock.
// - Source select: none, crystal, RC, fast/32.
// - Crystal drive field, reset to highest strength.
// - Bypass bit switches crystal to external clock.
// - Crystal enable starts it; stable flag follows.
// - Cause register resets 0x0C000000; flags power reset only.
// - Low-power reset sets flag bit 31.
// - Window watchdog reset sets flag bit 30.
// - Free watchdog reset sets flag bit 29.
// - Software reset sets flag bit 28.
// - Power reset sets flag bit 27.
// - Reset pin sets flag bit 26.
// - Option loader reset sets flag bit 25.
// - Core supply reset sets flag bit 23.
// - Writing one to bit 24 clears all flags.
// - RC enable starts oscillator; stable flag follows.
// - Byte, half-word and word accesses supported.
//
// The Avalon-MM slave port is this design's own decision.
module bkclk_top (
    // Clock and resets.
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pwr_rst,
    input wire logic bkp_pwr_rst,
    // Avalon-MM register slave.
    input wire logic [bkclk_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [bkclk_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [bkclk_pkg::BE_W-1:0] avs_byteenable,
    output logic [bkclk_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Power unit control.
    input wire logic backup_write_enable,
    // Reset cause events.
    input wire bkclk_pkg::bkclk_cause_evt_type cause_evt,
    // Oscillator status and clocks, sampled on ref_clk.
    input wire logic slow_crystal_ready,
    input wire logic slow_rc_ready,
    input wire logic slow_crystal_clock,
    input wire logic slow_rc_clock,
    input wire logic fast_crystal_clock,
    // Oscillator and backup domain controls.
    output bkclk_pkg::bkclk_xtal_ctl_type slow_crystal_ctl,
    output logic slow_rc_enable,
    output logic backup_domain_reset,
    output logic rtc_clock
);

    // Merges write data into an old word under the byte enables.
    function automatic logic [bkclk_pkg::DATA_W-1:0] merge_bytes(
        input logic [bkclk_pkg::DATA_W-1:0] old_word,
        input logic [bkclk_pkg::DATA_W-1:0] new_word,
        input logic [bkclk_pkg::BE_W-1:0] lanes
    );
        logic [bkclk_pkg::DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < bkclk_pkg::BE_W; i++) begin
            if (lanes[i]) begin
                result[i*bkclk_pkg::BYTE_W +: bkclk_pkg::BYTE_W] =
                    new_word[i*bkclk_pkg::BYTE_W +: bkclk_pkg::BYTE_W];
            end
        end
        return result;
    endfunction

    // Backup domain fields.
    logic bkp_rst_ctl_q;
    logic gate_q;
    logic [1:0] src_q;
    logic [1:0] drive_q;
    logic bypass_q;
    logic xtal_en_q;
    logic xtal_stb_q;

    // Reset cause flags and slow RC fields.
    logic flag_lp_q;
    logic flag_wwdg_q;
    logic flag_fwdg_q;
    logic flag_sw_q;
    logic flag_por_q;
    logic flag_pin_q;
    logic flag_obl_q;
    logic flag_core_q;
    logic flag_clr_q;
    logic rc_en_q;
    logic rc_stb_q;

    // Bus handshake state.
    logic waitreq_q;
    logic [bkclk_pkg::DATA_W-1:0] rdata_q;

    // Rtc clock path state.
    logic fast_prev_q;
    logic [bkclk_pkg::FAST_DIV_W-1:0] fast_div_q;
    logic rtc_clk_q;

    // Registered oscillator controls.
    bkclk_pkg::bkclk_xtal_ctl_type xtal_ctl_q;
    logic rc_en_out_q;
    logic bkp_rst_out_q;

    // Decoded bus terms.
    logic wr_fire;
    logic hit_bdc;
    logic hit_rsc;
    logic [bkclk_pkg::DATA_W-1:0] bdc_word;
    logic [bkclk_pkg::DATA_W-1:0] rsc_word;
    logic [bkclk_pkg::DATA_W-1:0] bdc_new;
    logic [bkclk_pkg::DATA_W-1:0] rsc_new;
    logic flag_clear;
    logic rtc_sel;

    // Non-cause bits of the cause register fall to reset on a system or a power reset.
    logic rsc_misc_rst;
    assign rsc_misc_rst = sys_rst | pwr_rst;

    // A write lands at the edge where the master sees waitrequest low.
    assign wr_fire = avs_write & ~waitreq_q;
    assign hit_bdc = (avs_address == bkclk_pkg::BDC_OFFSET);
    assign hit_rsc = (avs_address == bkclk_pkg::RSC_OFFSET);

    // Register images as software reads them; reserved bits read as zero.
    always_comb begin
        bdc_word = '0;
        bdc_word[bkclk_pkg::BDC_RST_BIT] = bkp_rst_ctl_q;
        bdc_word[bkclk_pkg::BDC_GATE_BIT] = gate_q;
        bdc_word[bkclk_pkg::BDC_SRC_LO +: 2] = src_q;
        bdc_word[bkclk_pkg::BDC_DRV_LO +: 2] = drive_q;
        bdc_word[bkclk_pkg::BDC_BYP_BIT] = bypass_q;
        bdc_word[bkclk_pkg::BDC_STB_BIT] = xtal_stb_q;
        bdc_word[bkclk_pkg::BDC_EN_BIT] = xtal_en_q;
    end

    // The cause register image.
    always_comb begin
        rsc_word = '0;
        rsc_word[bkclk_pkg::RSC_LP_BIT] = flag_lp_q;
        rsc_word[bkclk_pkg::RSC_WWDG_BIT] = flag_wwdg_q;
        rsc_word[bkclk_pkg::RSC_FWDG_BIT] = flag_fwdg_q;
        rsc_word[bkclk_pkg::RSC_SW_BIT] = flag_sw_q;
        rsc_word[bkclk_pkg::RSC_POR_BIT] = flag_por_q;
        rsc_word[bkclk_pkg::RSC_PIN_BIT] = flag_pin_q;
        rsc_word[bkclk_pkg::RSC_OBL_BIT] = flag_obl_q;
        rsc_word[bkclk_pkg::RSC_CLR_BIT] = flag_clr_q;
        rsc_word[bkclk_pkg::RSC_CORE_BIT] = flag_core_q;
        rsc_word[bkclk_pkg::RSC_RCSTB_BIT] = rc_stb_q;
        rsc_word[bkclk_pkg::RSC_RCEN_BIT] = rc_en_q;
    end

    // Merged write values; only the lanes the master enables change.
    assign bdc_new = merge_bytes(bdc_word, avs_writedata, avs_byteenable);
    assign rsc_new = merge_bytes(rsc_word, avs_writedata, avs_byteenable);

    // A one written to the clear bit wipes every cause flag this edge.
    assign flag_clear = wr_fire & hit_rsc & rsc_new[bkclk_pkg::RSC_CLR_BIT];

    // Every access takes two cycles: request, then one cycle of waitrequest low.
    // Read data is captured with the request, so it stands at the answering edge.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitreq_q <= 1'b1;
            rdata_q <= '0;
        end else if (!waitreq_q) begin
            // The answer was given; raise waitrequest for the next request.
            waitreq_q <= 1'b1;
        end else if (avs_read || avs_write) begin
            waitreq_q <= 1'b0;
            if (avs_read && hit_bdc) begin
                rdata_q <= bdc_word;
            end else if (avs_read && hit_rsc) begin
                rdata_q <= rsc_word;
            end else begin
                // Unmapped reads and all writes answer zero.
                rdata_q <= '0;
            end
        end
    end

    // The backup reset control bit lives in the backup register but is not
    // cleared by the reset it drives, or it would release itself at once.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            bkp_rst_ctl_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_RST_BIT];
        end else if (wr_fire && hit_bdc) begin
            bkp_rst_ctl_q <= bdc_new[bkclk_pkg::BDC_RST_BIT];
        end
    end

    // Protected backup fields: cleared only by a backup domain reset, and
    // changed only while the power unit grants backup write access.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            gate_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_GATE_BIT];
            src_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_SRC_LO +: 2];
            bypass_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_BYP_BIT];
            xtal_en_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_EN_BIT];
        end else if (bkp_rst_ctl_q) begin
            // Software backup reset holds these at their reset values.
            gate_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_GATE_BIT];
            src_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_SRC_LO +: 2];
            bypass_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_BYP_BIT];
            xtal_en_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_EN_BIT];
        end else if (wr_fire && hit_bdc && backup_write_enable) begin
            gate_q <= bdc_new[bkclk_pkg::BDC_GATE_BIT];
            src_q <= bdc_new[bkclk_pkg::BDC_SRC_LO +: 2];
            bypass_q <= bdc_new[bkclk_pkg::BDC_BYP_BIT];
            xtal_en_q <= bdc_new[bkclk_pkg::BDC_EN_BIT];
        end
    end

    // Drive strength is not write protected but is still a backup field.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            drive_q <= bkclk_pkg::DRV_RESET;
        end else if (bkp_rst_ctl_q) begin
            drive_q <= bkclk_pkg::DRV_RESET;
        end else if (wr_fire && hit_bdc) begin
            drive_q <= bdc_new[bkclk_pkg::BDC_DRV_LO +: 2];
        end
    end

    // Crystal stable flag follows the cell's ready only while enabled, so it
    // drops in the cycle after the enable is cleared.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            xtal_stb_q <= bkclk_pkg::BDC_RESET[bkclk_pkg::BDC_STB_BIT];
        end else begin
            xtal_stb_q <= xtal_en_q & slow_crystal_ready & ~bkp_rst_ctl_q;
        end
    end

    // Crystal cell controls, registered so the outputs come from flops.
    // Drive is passed even in bypass; the cell ignores it there.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            xtal_ctl_q <= '0;
            bkp_rst_out_q <= 1'b0;
        end else begin
            xtal_ctl_q.enable <= xtal_en_q;
            xtal_ctl_q.bypass <= bypass_q;
            xtal_ctl_q.drive <= drive_q;
            bkp_rst_out_q <= bkp_rst_ctl_q;
        end
    end

    // Cause flags: of the resets only a power reset clears them, and it leaves the power
    // and pin flags set. A new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or posedge pwr_rst) begin
        if (pwr_rst) begin
            flag_lp_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_LP_BIT];
            flag_wwdg_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_WWDG_BIT];
            flag_fwdg_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_FWDG_BIT];
            flag_sw_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_SW_BIT];
            flag_por_q <= bkclk_pkg::FLAG_POR_RESET;
            flag_pin_q <= bkclk_pkg::FLAG_PIN_RESET;
            flag_obl_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_OBL_BIT];
            flag_core_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_CORE_BIT];
        end else begin
            flag_lp_q <= cause_evt.low_power | (flag_lp_q & ~flag_clear);
            flag_wwdg_q <= cause_evt.window_wdg | (flag_wwdg_q & ~flag_clear);
            flag_fwdg_q <= cause_evt.free_wdg | (flag_fwdg_q & ~flag_clear);
            flag_sw_q <= cause_evt.software | (flag_sw_q & ~flag_clear);
            flag_por_q <= flag_por_q & ~flag_clear;
            flag_pin_q <= cause_evt.pin | (flag_pin_q & ~flag_clear);
            flag_obl_q <= cause_evt.option_loader | (flag_obl_q & ~flag_clear);
            flag_core_q <= cause_evt.core_supply | (flag_core_q & ~flag_clear);
        end
    end

    // Clear bit and RC enable are ordinary system-reset bits.
    always_ff @(posedge ref_clk or posedge rsc_misc_rst) begin
        if (rsc_misc_rst) begin
            flag_clr_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_CLR_BIT];
            rc_en_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_RCEN_BIT];
        end else if (wr_fire && hit_rsc) begin
            flag_clr_q <= rsc_new[bkclk_pkg::RSC_CLR_BIT];
            rc_en_q <= rsc_new[bkclk_pkg::RSC_RCEN_BIT];
        end
    end

    // RC stable flag and registered RC enable output.
    always_ff @(posedge ref_clk or posedge rsc_misc_rst) begin
        if (rsc_misc_rst) begin
            rc_stb_q <= bkclk_pkg::RSC_RESET[bkclk_pkg::RSC_RCSTB_BIT];
            rc_en_out_q <= 1'b0;
        end else begin
            rc_stb_q <= rc_en_q & slow_rc_ready;
            rc_en_out_q <= rc_en_q;
        end
    end

    // Fast crystal divider: counts rising edges of the sampled fast clock.
    // Sampling limits the fast crystal to below half of ref_clk.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_prev_q <= 1'b0;
            fast_div_q <= '0;
        end else begin
            fast_prev_q <= fast_crystal_clock;
            if (fast_crystal_clock && !fast_prev_q) begin
                fast_div_q <= fast_div_q + 1'b1;
            end
        end
    end

    // Rtc source multiplexer.
    always_comb begin
        unique case (src_q)
            bkclk_pkg::RTC_SRC_NONE: rtc_sel = 1'b0;
            bkclk_pkg::RTC_SRC_XTAL: rtc_sel = slow_crystal_clock;
            bkclk_pkg::RTC_SRC_RC: rtc_sel = slow_rc_clock;
            bkclk_pkg::RTC_SRC_FAST: rtc_sel = fast_div_q[bkclk_pkg::FAST_DIV_W-1];
        endcase
    end

    // Gated rtc clock, retimed to ref_clk; blocked while gate is zero or the
    // backup domain is held in reset.
    always_ff @(posedge ref_clk or posedge bkp_pwr_rst) begin
        if (bkp_pwr_rst) begin
            rtc_clk_q <= 1'b0;
        end else begin
            rtc_clk_q <= rtc_sel & gate_q & ~bkp_rst_ctl_q;
        end
    end

    // Output assignments, all from flops.
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = waitreq_q;
    assign slow_crystal_ctl = xtal_ctl_q;
    assign slow_rc_enable = rc_en_out_q;
    assign backup_domain_reset = bkp_rst_out_q;
    assign rtc_clock = rtc_clk_q;

endmodule

// ===== common/bkclk_pkg.sv
package bkclk_pkg;

    // Bus geometry of the register slave.
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned BYTE_W = 8;

    // Byte addresses of the two registers.
    localparam logic [ADDR_W-1:0] BDC_OFFSET = 6'h20;
    localparam logic [ADDR_W-1:0] RSC_OFFSET = 6'h24;

    // Reset values of the two registers.
    localparam logic [DATA_W-1:0] BDC_RESET = 32'h0000_0018;
    localparam logic [DATA_W-1:0] RSC_RESET = 32'h0C00_0000;

    // Field positions in the backup domain control register.
    localparam int unsigned BDC_RST_BIT = 16;
    localparam int unsigned BDC_GATE_BIT = 15;
    localparam int unsigned BDC_SRC_LO = 8;
    localparam int unsigned BDC_DRV_LO = 3;
    localparam int unsigned BDC_BYP_BIT = 2;
    localparam int unsigned BDC_STB_BIT = 1;
    localparam int unsigned BDC_EN_BIT = 0;

    // Field positions in the reset cause and slow RC register.
    localparam int unsigned RSC_LP_BIT = 31;
    localparam int unsigned RSC_WWDG_BIT = 30;
    localparam int unsigned RSC_FWDG_BIT = 29;
    localparam int unsigned RSC_SW_BIT = 28;
    localparam int unsigned RSC_POR_BIT = 27;
    localparam int unsigned RSC_PIN_BIT = 26;
    localparam int unsigned RSC_OBL_BIT = 25;
    localparam int unsigned RSC_CLR_BIT = 24;
    localparam int unsigned RSC_CORE_BIT = 23;
    localparam int unsigned RSC_RCSTB_BIT = 1;
    localparam int unsigned RSC_RCEN_BIT = 0;

    // Reset values of the individual fields, taken from the register reset values.
    localparam logic [1:0] DRV_RESET = BDC_RESET[BDC_DRV_LO+1:BDC_DRV_LO];
    localparam logic FLAG_POR_RESET = RSC_RESET[RSC_POR_BIT];
    localparam logic FLAG_PIN_RESET = RSC_RESET[RSC_PIN_BIT];

    // Codes of the rtc source select field.
    localparam logic [1:0] RTC_SRC_NONE = 2'h0;
    localparam logic [1:0] RTC_SRC_XTAL = 2'h1;
    localparam logic [1:0] RTC_SRC_RC = 2'h2;
    localparam logic [1:0] RTC_SRC_FAST = 2'h3;

    // The fast crystal is divided by two to the power of this width, that is 32.
    localparam int unsigned FAST_DIV_W = 5;

    // One-cycle reset cause events from the reset controller.
    typedef struct packed {
        logic low_power;
        logic window_wdg;
        logic free_wdg;
        logic software;
        logic pin;
        logic option_loader;
        logic core_supply;
    } bkclk_cause_evt_type;

    // Controls sent to the slow crystal oscillator cell.
    typedef struct packed {
        logic enable;
        logic bypass;
        logic [1:0] drive;
    } bkclk_xtal_ctl_type;

endpackage

// ===== tb/bkclk_chk.sv
module bkclk_chk (
    // Clock and resets.
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pwr_rst,
    input wire logic bkp_pwr_rst,
    // Register bus and write protection.
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic backup_write_enable,
    // Oscillator and backup controls.
    input wire bkclk_pkg::bkclk_xtal_ctl_type slow_crystal_ctl,
    input wire logic slow_rc_enable,
    input wire logic backup_domain_reset,
    input wire logic rtc_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    // Every reset moves some output, so any of them pauses checking.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst || pwr_rst || bkp_pwr_rst);

    // Answer cycles of writes to each register and of reads.
    logic wr_bdc;
    logic wr_rsc;
    logic rd_done;
    assign wr_bdc = avs_write && !avs_waitrequest && avs_address == bkclk_pkg::BDC_OFFSET;
    assign wr_rsc = avs_write && !avs_waitrequest && avs_address == bkclk_pkg::RSC_OFFSET;
    assign rd_done = avs_read && !avs_waitrequest;

    wait_one_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Request was not answered in the next cycle.");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request stayed low for more than one cycle.");
    unmapped_zero_a: assert property (
        rd_done && avs_address != bkclk_pkg::BDC_OFFSET
        && avs_address != bkclk_pkg::RSC_OFFSET |-> avs_readdata == 32'h0)
        else $error("Unmapped read returned data.");
    reserved_zero_a: assert property (
        rd_done |-> (avs_readdata & (avs_address == bkclk_pkg::RSC_OFFSET ?
        32'h007F_FFFC : 32'hFFFE_7CE0)) == 32'h0)
        else $error("Reserved bits read as one.");
    bkp_hold_a: assert property (
        backup_domain_reset [*2] |-> slow_crystal_ctl == 4'h3 && !rtc_clock)
        else $error("Backup reset did not hold controls at reset values.");
    rst_ctl_a: assert property (
        wr_bdc && avs_byteenable[2] |-> ##2 backup_domain_reset == $past(avs_writedata[16], 2))
        else $error("Backup reset output does not follow the written bit.");
    rc_out_a: assert property (
        wr_rsc && avs_byteenable[0] |-> ##2 slow_rc_enable == $past(avs_writedata[0], 2))
        else $error("RC enable output does not follow the written bit.");
    drive_out_a: assert property (
        wr_bdc && avs_byteenable[0] && !backup_domain_reset && !avs_writedata[16]
        |-> ##2 slow_crystal_ctl.drive == $past(avs_writedata[4:3], 2))
        else $error("Drive output does not follow the written field.");
    en_write_a: assert property (
        wr_bdc && avs_byteenable[0] && !backup_domain_reset && !avs_writedata[16]
        && backup_write_enable |-> ##2 slow_crystal_ctl.enable == $past(avs_writedata[0], 2)
        && slow_crystal_ctl.bypass == $past(avs_writedata[2], 2))
        else $error("Enabled write did not reach crystal controls.");
    en_keep_a: assert property (
        wr_bdc && avs_byteenable[0] && !backup_domain_reset && !avs_writedata[16]
        && !backup_write_enable
        |-> ##2 slow_crystal_ctl.enable == $past(slow_crystal_ctl.enable, 2))
        else $error("Protected crystal enable changed without write enable.");
endmodule

bind bkclk_top bkclk_chk u_bkclk_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .pwr_rst(pwr_rst), .bkp_pwr_rst(bkp_pwr_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .backup_write_enable(backup_write_enable), .slow_crystal_ctl(slow_crystal_ctl),
    .slow_rc_enable(slow_rc_enable), .backup_domain_reset(backup_domain_reset),
    .rtc_clock(rtc_clock)
);

// ===== tb/test_backup_clock_and_reset_flags.sv
module test_backup_clock_and_reset_flags;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] BDC = bkclk_pkg::BDC_OFFSET;
    localparam logic [5:0] RSC = bkclk_pkg::RSC_OFFSET;
    // Design inputs, all given values at time zero.
    logic ref_clk = 0, sys_rst = 1, pwr_rst = 1, bkp_pwr_rst = 1;
    logic [5:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0, backup_write_enable = 0;
    logic [31:0] avs_writedata = 0;
    logic [3:0] avs_byteenable = 0;
    bkclk_pkg::bkclk_cause_evt_type cause_evt = '0;
    logic slow_crystal_ready = 1, slow_rc_ready = 1;
    logic slow_crystal_clock = 0, slow_rc_clock = 0, fast_crystal_clock = 0;
    // Design outputs.
    logic [31:0] avs_readdata;
    logic avs_waitrequest, slow_rc_enable, backup_domain_reset, rtc_clock;
    bkclk_pkg::bkclk_xtal_ctl_type slow_crystal_ctl;
    // Reference model state, counters and the random seed.
    logic [31:0] bdc_m, rsc_m, rd;
    logic [7:0] cyc = 0;
    int errors = 0, checks = 0, seed = 32'hc289;
    int fb[7] = '{23, 25, 26, 28, 29, 30, 31};
    int tbl[4] = '{0, 80, 40, 10};

    bkclk_top u_bkclk_top (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .pwr_rst(pwr_rst), .bkp_pwr_rst(bkp_pwr_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .backup_write_enable(backup_write_enable), .cause_evt(cause_evt),
        .slow_crystal_ready(slow_crystal_ready), .slow_rc_ready(slow_rc_ready),
        .slow_crystal_clock(slow_crystal_clock), .slow_rc_clock(slow_rc_clock),
        .fast_crystal_clock(fast_crystal_clock), .slow_crystal_ctl(slow_crystal_ctl),
        .slow_rc_enable(slow_rc_enable), .backup_domain_reset(backup_domain_reset),
        .rtc_clock(rtc_clock)
    );

    // Free-running 250 MHz clock.
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Source clocks: fast toggles each cycle, crystal period 8, RC period 16 cycles.
    always @(posedge ref_clk) begin
        cyc <= cyc + 8'h1;
        fast_crystal_clock <= ~fast_crystal_clock;
        slow_crystal_clock <= cyc[2];
        slow_rc_clock <= cyc[3];
    end

    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected read word; stable flags follow enable and ready.
    function automatic logic [31:0] expv(input logic [5:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a == BDC) begin
            v = bdc_m;
            v[1] = bdc_m[0] & slow_crystal_ready & ~bdc_m[16];
        end else if (a == RSC) begin
            v = rsc_m;
            v[1] = rsc_m[0] & slow_rc_ready;
        end
        return v;
    endfunction

    // One Avalon access; the request stands until wait request is seen low.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        logic [31:0] m, k, v;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        k = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (w && a == BDC) begin
            m = (bdc_m & ~k) | (d & k);
            v = bdc_m;
            v[16] = m[16];
            v[4:3] = m[4:3];
            if (backup_write_enable && !bdc_m[16]) begin
                v[15] = m[15];
                v[9:8] = m[9:8];
                v[2] = m[2];
                v[0] = m[0];
            end
            if (v[16] || bdc_m[16]) v = 32'h18 | (v & 32'h0001_0000);
            bdc_m = v;
        end
        if (w && a == RSC) begin
            m = (rsc_m & ~k) | (d & k);
            rsc_m[24] = m[24];
            rsc_m[0] = m[0];
            if (m[24]) rsc_m = rsc_m & ~32'hFE80_0000;
        end
        if (n >= 40) chk(32'h0, 32'h1);
    endtask

    // Read one register and compare it with the model.
    task automatic rdc(input logic [5:0] a, input logic [3:0] be);
        bus(1'b0, a, 32'h0, be);
        chk(rd, expv(a));
    endtask

    // Counts rising edges of the rtc clock over 640 cycles, two edges of slack.
    task automatic cnt(input int exp);
        int r;
        logic p;
        r = 0;
        p = rtc_clock;
        repeat (640) begin
            @(posedge ref_clk);
            if (rtc_clock && !p) r++;
            p = rtc_clock;
        end
        chk(32'((r >= exp - 2) && (r <= exp + 2)), 32'h1);
    endtask

    // Pulses the chosen resets (system, power, backup) for three cycles.
    task automatic rstp(input logic [2:0] w);
        @(posedge ref_clk);
        {bkp_pwr_rst, pwr_rst, sys_rst} <= w;
        repeat (3) @(posedge ref_clk);
        {bkp_pwr_rst, pwr_rst, sys_rst} <= 3'b000;
        if (w[1:0] != 2'b00) rsc_m = rsc_m & ~32'h0100_0003;
        if (w[1]) rsc_m = 32'h0C00_0000;
        if (w[2]) bdc_m = 32'h18;
    endtask

    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        $display("MISMATCH %0t run did not finish", $time);
        print_verdict;
    end

    // Main sequence.
    initial begin
        bdc_m = 32'h18;
        rsc_m = 32'h0C00_0000;
        repeat (20) @(posedge ref_clk);
        {bkp_pwr_rst, pwr_rst, sys_rst} <= 3'b000;
        rdc(BDC, 4'hF);
        rdc(RSC, 4'hF);
        bus(1'b1, 6'h28, 32'hFFFF_FFFF, 4'hF);
        rdc(6'h28, 4'hF);
        bus(1'b1, BDC, 32'h0000_830D, 4'hF);
        rdc(BDC, 4'h1);
        backup_write_enable <= 1'b1;
        bus(1'b1, BDC, 32'h0000_830D, 4'hF);
        rdc(BDC, 4'h3);
        chk({28'h0, slow_crystal_ctl}, 32'hD);
        slow_crystal_ready <= 1'b0;
        rdc(BDC, 4'hF);
        slow_crystal_ready <= 1'b1;
        bus(1'b1, BDC, 32'h0, 4'h1);
        rdc(BDC, 4'hF);
        for (int v = 1; v >= 0; v--) begin
            bus(1'b1, RSC, 32'(v), 4'h1);
            rdc(RSC, 4'hF);
            chk({31'h0, slow_rc_enable}, 32'(v));
        end
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, BDC, {16'h0, 6'h20, 2'(s), 8'h0}, 4'h2);
            cnt(tbl[s]);
        end
        bus(1'b1, BDC, 32'h0, 4'h2);
        cnt(0);
        bus(1'b1, RSC, 32'h0100_0000, 4'h8);
        rdc(RSC, 4'hF);
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            cause_evt <= bkclk_pkg::bkclk_cause_evt_type'(7'h01 << i);
            @(posedge ref_clk);
            cause_evt <= '0;
            rsc_m[fb[i]] = 1'b1;
            rdc(RSC, 4'hF);
        end
        bus(1'b1, RSC, 32'h0, 4'h8);
        rdc(RSC, 4'hF);
        bus(1'b1, BDC, 32'h0000_8105, 4'hF);
        bus(1'b1, RSC, 32'h1, 4'h1);
        rstp(3'b001);
        rdc(BDC, 4'hF);
        rdc(RSC, 4'hF);
        rstp(3'b010);
        rdc(RSC, 4'hF);
        rdc(BDC, 4'hF);
        bus(1'b1, BDC, 32'h0001_0000, 4'h4);
        rdc(BDC, 4'hF);
        chk({31'h0, backup_domain_reset}, 32'h1);
        bus(1'b1, BDC, 32'h18, 4'hF);
        rdc(BDC, 4'hF);
        bus(1'b1, BDC, 32'h0000_8305, 4'hF);
        rstp(3'b100);
        rdc(BDC, 4'hF);
        repeat (40) begin
            backup_write_enable <= 1'($random(seed));
            bus(1'b1, BDC, $random(seed) & 32'hFFFE_FFFF, 4'($random(seed)));
            rdc(BDC, 4'($random(seed)));
        end
        print_verdict;
    end
endmodule
